// File: core/fip_tail_pkg.sv
// constants shared by the frame initialization packet tail parser and its crc engine
//----------------------------------------------------------------------------
// Overview of operation
// - parameter word positions 0..21 hold three groups of signalling bits
// - word positions 23:22 give bandwidth: 7, 8, 6 MHz or other
// - word position 24 set means high priority or non-hierarchical stream
// - addressing length byte is the byte count of the address field
// - addressing length zero means the crc word follows at once
// - addressing length 0xff means one group address is carried
// - other addressing lengths walk a loop of unicast transmitter addresses
// - addresses are 16 bits; 0x0000 matches every transmitter
// - crc over the section must leave the checker registers at zero
// - every byte after the crc word holds 0xff
// - loop length byte is the byte count of all commands
// - each command has code and length; length steps to next command
// - command codes 0x00 to 0x0a defined, the rest reserved
// - any command may be missing without harming operation
// - time shift is code, length and a 16-bit signed offset
// - time shift counts 100 ns steps, range -32768 to +32767
// - shift applies to stamp plus maximum delay, modulo ten million
// - a packet is always 188 bytes, header plus payload
// - packets are recognised by packet identifier 0x15
// - section byte count covers bytes up to crc, never above 182
// - parameter word applies two frames on, other values one frame on
//----------------------------------------------------------------------------
package fip_tail_pkg;

   //-------------------------------------------------------------------------
   // packet layout
   //-------------------------------------------------------------------------
   localparam logic [7:0]  POS_LAST     = 8'hbb;   // byte 187 of 188
   localparam logic [7:0]  SYNC_BYTE    = 8'h47;
   localparam logic [12:0] PID_FIP      = 13'h0015;
   localparam logic [7:0]  POS_PID_HI   = 8'h01;
   localparam logic [7:0]  POS_PID_LO   = 8'h02;
   localparam logic [7:0]  POS_CRC_FROM = 8'h04;   // crc starts at sync id
   localparam logic [7:0]  POS_SEC_LEN  = 8'h05;
   localparam logic [7:0]  POS_STAMP_0  = 8'h0a;
   localparam logic [7:0]  POS_STAMP_2  = 8'h0c;
   localparam logic [7:0]  POS_MAXD_0   = 8'h0d;
   localparam logic [7:0]  POS_MAXD_2   = 8'h0f;
   localparam logic [7:0]  POS_TPS_0    = 8'h10;
   localparam logic [7:0]  POS_TPS_3    = 8'h13;
   localparam logic [7:0]  POS_ADDR_LEN = 8'h14;
   localparam logic [7:0]  SEC_MAX      = 8'hb6;   // 182
   localparam logic [7:0]  ADDR_NONE    = 8'h00;
   localparam logic [7:0]  ADDR_MCAST   = 8'hff;
   localparam logic [7:0]  MCAST_BYTES  = 8'h02;   // one group address
   localparam logic [15:0] TX_BCAST     = 16'h0000;
   localparam logic [7:0]  PAD_BYTE     = 8'hff;

   //-------------------------------------------------------------------------
   // commands and parameter word fields
   //-------------------------------------------------------------------------
   localparam logic [7:0]  TAG_TIME_SHIFT = 8'h00;
   localparam logic [7:0]  TAG_LAST       = 8'h0a;
   localparam int          SEEN_RSVD      = 11;
   localparam int          TPS_RSVD_LO    = 25;
   localparam int          TPS_PRIO       = 24;
   localparam int          TPS_BW_LO      = 22;
   localparam logic [1:0]  BW_7MHZ        = 2'h0;
   localparam logic [1:0]  BW_8MHZ        = 2'h1;
   localparam logic [1:0]  BW_6MHZ        = 2'h2;
   localparam logic [1:0]  BW_OTHER       = 2'h3;

   //-------------------------------------------------------------------------
   // timing
   //-------------------------------------------------------------------------
   localparam int          TIME_UNIT_NS   = 100;
   localparam logic [25:0] EMIT_MODULUS   = 26'h0989680;   // ten million

   //-------------------------------------------------------------------------
   // crc
   //-------------------------------------------------------------------------
   localparam logic [31:0] CRC_POLY = 32'h04c11db7;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;

   //-------------------------------------------------------------------------
   // register map, byte offsets, and reset values
   //-------------------------------------------------------------------------
   localparam logic [5:0]  OFF_CTRL   = 6'h00;
   localparam logic [5:0]  OFF_TXID   = 6'h04;
   localparam logic [5:0]  OFF_STATUS = 6'h08;
   localparam logic [5:0]  OFF_TPS    = 6'h0c;
   localparam logic [5:0]  OFF_SHIFT  = 6'h10;
   localparam logic [5:0]  OFF_EMIT   = 6'h14;
   localparam logic [5:0]  OFF_SEEN   = 6'h18;
   localparam logic [5:0]  OFF_REF    = 6'h1c;
   localparam logic        RST_ENABLE = 1'b1;
   localparam logic [15:0] RST_OWN_ID = 16'h0001;
   localparam logic [15:0] RST_GRP_ID = 16'h0001;
   localparam int          ST_OK      = 0;
   localparam int          ST_CRC     = 1;
   localparam int          ST_FMT     = 2;
   localparam int          ST_RSVD    = 3;
   localparam int          ST_PAD     = 4;

endpackage

// File: core/crc32_byte.sv
// byte-wide crc-32 engine, msb first, for section checking
`timescale 1ns/1ps
`default_nettype none
module crc32_byte (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // byte feed
   input  wire logic        clear_i,
   input  wire logic        enable_i,
   input  wire logic [7:0]  data_i,
   // remainder
   output logic      [31:0] crc_o
);

   typedef struct packed {
      logic [31:0] crc;
   } crc_state_t;

   crc_state_t r;
   crc_state_t n;

   // one byte through the polynomial, high bit first
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] v;
      logic        fb;
      v = c;
      for (int i = 7; i >= 0; i--) begin
         fb = v[31] ^ d[i];
         v = {v[30:0], 1'b0} ^ (fb ? fip_tail_pkg::CRC_POLY : 32'h00000000);
      end
      return v;
   endfunction

   // clear at packet start, fold in each section byte
   always_comb begin
      n = r;
      if (clear_i) begin
         n.crc = fip_tail_pkg::CRC_INIT;
      end else if (enable_i) begin
         n.crc = crc_step(r.crc, data_i);
      end
      if (rst_i) begin
         n.crc = fip_tail_pkg::CRC_INIT;
      end
   end

   always_ff @(posedge clk_i) begin
      r <= n;
   end

   assign crc_o = r.crc;

endmodule
`default_nettype wire

// File: core/fip_tail_parser.sv
// frame initialization packet parser with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
module fip_tail_parser (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // transport stream bytes
   input  wire logic [7:0]  byte_i,
   input  wire logic        byte_valid_i,
   input  wire logic        pkt_start_i,
   // frame boundary from the modulator
   input  wire logic        frame_start_i,
   // avalon-mm slave
   input  wire logic [5:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   output logic      [31:0] readdata_o,
   output logic             waitrequest_o,
   // applied parameters
   output logic      [21:0] tps_param_o,
   output logic      [1:0]  bw_code_o,
   output logic             hp_stream_o,
   output logic      [15:0] time_shift_o,
   output logic      [23:0] ref_time_o,
   output logic      [23:0] emit_time_o,
   // packet verdict pulses
   output logic             pkt_ok_o,
   output logic             pkt_err_o
);

   typedef enum logic [3:0] {
      IDLE, FIXED, ADDR, LOOP_LEN, CMD_TAG, CMD_LEN, CMD_BODY, CRC, PAD, SKIP
   } parse_t;

   typedef struct packed {
      parse_t      st;
      logic [7:0]  pos, sec_rem, addr_rem, id_hi, loop_rem, tag, body_rem, ts_hi;
      logic [4:0]  pid_hi, status;
      logic [23:0] frame_sync_stamp, maxd, stamp_pend, maxd_pend, ref_act, emit_act;
      logic [31:0] tps, tps_pend, tps_mid, tps_act, rdata;
      logic [15:0] ts_pkt, ts_pend, ts_act, own_id, grp_id;
      logic [11:0] seen_pkt, seen;
      logic [1:0]  body_idx, crc_cnt;
      logic        mcast, id_phase, match, ts_ok, crc_chk, enable, waitreq, ok_p, err_p;
   } parser_state_t;

   parser_state_t r;
   parser_state_t n;

   logic [31:0] crc;
   logic        crc_clr;
   logic        crc_en;
   logic        in_sec;

   //-------------------------------------------------------------------------
   // helpers
   //-------------------------------------------------------------------------

   // fold a signed sum back into one second of 100 ns steps
   function automatic logic [23:0] wrap_second(input logic signed [25:0] v);
      logic signed [25:0] m;
      logic signed [25:0] w;
      m = fip_tail_pkg::EMIT_MODULUS;
      w = v;
      if (w < 26'sh0000000) begin
         w = w + m;
      end else if (w >= m) begin
         w = w - m;
      end
      return w[23:0];
   endfunction

   logic [23:0] ref_next;
   logic [23:0] emit_next;

   // reference emission time and shifted emission time
   always_comb begin
      ref_next = wrap_second(26'({2'b00, r.stamp_pend} + {2'b00, r.maxd_pend}));
      emit_next = wrap_second(26'($signed({2'b00, ref_next}) +
                                  $signed({{10{r.ts_pend[15]}}, r.ts_pend})));
   end

   //-------------------------------------------------------------------------
   // crc engine
   //-------------------------------------------------------------------------
   assign in_sec = (r.st != IDLE) && (r.st != SKIP) && (r.st != PAD) &&
                   (r.pos > fip_tail_pkg::POS_SEC_LEN);
   assign crc_clr = byte_valid_i && pkt_start_i;
   assign crc_en = byte_valid_i && !pkt_start_i && (r.st != IDLE) && (r.st != SKIP) &&
                   (r.st != PAD) && (r.pos >= fip_tail_pkg::POS_CRC_FROM);

   crc32_byte u_crc (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .clear_i  (crc_clr),
      .enable_i (crc_en),
      .data_i   (byte_i),
      .crc_o    (crc)
   );

   //-------------------------------------------------------------------------
   // next state
   //-------------------------------------------------------------------------
   always_comb begin
      logic [4:0]  set;
      logic [4:0]  clr;
      logic        fmt;
      logic [15:0] id;
      logic [7:0]  rem;
      set = 5'h00;
      clr = 5'h00;
      fmt = 1'b0;
      id = 16'h0000;
      rem = 8'h00;
      n = r;
      n.ok_p = 1'b0;
      n.err_p = 1'b0;

      // bus slave: one wait cycle, then answer
      if (r.waitreq) begin
         if (read_i || write_i) begin
            n.waitreq = 1'b0;
         end
         if (read_i) begin
            unique case (address_i)
               fip_tail_pkg::OFF_CTRL:   n.rdata = {31'h00000000, r.enable};
               fip_tail_pkg::OFF_TXID:   n.rdata = {r.grp_id, r.own_id};
               fip_tail_pkg::OFF_STATUS: n.rdata = {27'h0000000, r.status};
               fip_tail_pkg::OFF_TPS:    n.rdata = r.tps_act;
               fip_tail_pkg::OFF_SHIFT:  n.rdata = {16'h0000, r.ts_act};
               fip_tail_pkg::OFF_EMIT:   n.rdata = {8'h00, r.emit_act};
               fip_tail_pkg::OFF_SEEN:   n.rdata = {20'h00000, r.seen};
               fip_tail_pkg::OFF_REF:    n.rdata = {8'h00, r.ref_act};
               default:                  n.rdata = 32'h00000000;
            endcase
         end
      end else begin
         n.waitreq = 1'b1;
         if (write_i) begin
            unique case (address_i)
               fip_tail_pkg::OFF_CTRL: n.enable = writedata_i[0];
               fip_tail_pkg::OFF_TXID: begin
                  n.own_id = writedata_i[15:0];
                  n.grp_id = writedata_i[31:16];
               end
               fip_tail_pkg::OFF_STATUS: clr = writedata_i[4:0];
               default: ;
            endcase
         end
      end

      // frame boundary: word moves two frames on, others one
      if (frame_start_i) begin
         n.tps_mid = r.tps_pend;
         n.tps_act = r.tps_mid;
         n.ts_act = r.ts_pend;
         n.ref_act = ref_next;
         n.emit_act = emit_next;
      end

      // crc verdict one cycle after the last crc byte
      if (r.crc_chk) begin
         n.crc_chk = 1'b0;
         if (crc != 32'h00000000) begin
            set[fip_tail_pkg::ST_CRC] = 1'b1;
            n.err_p = 1'b1;
         end else begin
            set[fip_tail_pkg::ST_OK] = 1'b1;
            n.ok_p = 1'b1;
            n.tps_pend = r.tps;
            n.stamp_pend = r.frame_sync_stamp;
            n.maxd_pend = r.maxd;
            if (r.tps[31:fip_tail_pkg::TPS_RSVD_LO] != 7'h00) begin
               set[fip_tail_pkg::ST_RSVD] = 1'b1;
            end
            if (r.match) begin
               n.seen = r.seen_pkt;
               if (r.ts_ok) begin
                  n.ts_pend = r.ts_pkt;
               end
            end
         end
      end

      // byte parser
      if (byte_valid_i && r.enable) begin
         if (pkt_start_i) begin
            n.pos = fip_tail_pkg::POS_PID_HI;
            n.st = (byte_i == fip_tail_pkg::SYNC_BYTE) ? FIXED : SKIP;
            n.match = 1'b0;
            n.mcast = 1'b0;
            n.id_phase = 1'b0;
            n.ts_ok = 1'b0;
            n.seen_pkt = 12'h000;
            n.crc_cnt = 2'h0;
            n.crc_chk = 1'b0;
         end else begin
            n.pos = r.pos + 8'h01;
            if (in_sec) begin
               n.sec_rem = r.sec_rem - 8'h01;
            end
            unique case (r.st)
               IDLE, SKIP: ;
               FIXED: begin
                  if (r.pos == fip_tail_pkg::POS_PID_HI) begin
                     n.pid_hi = byte_i[4:0];
                  end else if (r.pos == fip_tail_pkg::POS_PID_LO) begin
                     if ({r.pid_hi, byte_i} != fip_tail_pkg::PID_FIP) begin
                        n.st = SKIP;
                     end
                  end else if (r.pos == fip_tail_pkg::POS_SEC_LEN) begin
                     n.sec_rem = byte_i;
                     fmt = (byte_i > fip_tail_pkg::SEC_MAX);
                  end else if (r.pos >= fip_tail_pkg::POS_STAMP_0 &&
                               r.pos <= fip_tail_pkg::POS_STAMP_2) begin
                     n.frame_sync_stamp = {r.frame_sync_stamp[15:0], byte_i};
                  end else if (r.pos >= fip_tail_pkg::POS_MAXD_0 &&
                               r.pos <= fip_tail_pkg::POS_MAXD_2) begin
                     n.maxd = {r.maxd[15:0], byte_i};
                  end else if (r.pos >= fip_tail_pkg::POS_TPS_0 &&
                               r.pos <= fip_tail_pkg::POS_TPS_3) begin
                     n.tps = {r.tps[23:0], byte_i};
                  end else if (r.pos == fip_tail_pkg::POS_ADDR_LEN) begin
                     if (byte_i == fip_tail_pkg::ADDR_NONE) begin
                        n.match = 1'b1;
                        n.st = CRC;
                     end else if (byte_i == fip_tail_pkg::ADDR_MCAST) begin
                        n.mcast = 1'b1;
                        n.addr_rem = fip_tail_pkg::MCAST_BYTES;
                        n.st = ADDR;
                     end else begin
                        fmt = byte_i[0];
                        n.addr_rem = byte_i;
                        n.st = ADDR;
                     end
                  end
               end
               ADDR: begin
                  n.id_phase = !r.id_phase;
                  n.addr_rem = r.addr_rem - 8'h01;
                  id = {r.id_hi, byte_i};
                  if (!r.id_phase) begin
                     n.id_hi = byte_i;
                  end else if (id == fip_tail_pkg::TX_BCAST ||
                               id == (r.mcast ? r.grp_id : r.own_id)) begin
                     n.match = 1'b1;
                  end
                  if (r.addr_rem == 8'h01) begin
                     n.st = LOOP_LEN;
                  end
               end
               LOOP_LEN: begin
                  n.loop_rem = byte_i;
                  n.st = (byte_i == 8'h00) ? CRC : CMD_TAG;
               end
               CMD_TAG: begin
                  n.tag = byte_i;
                  n.loop_rem = r.loop_rem - 8'h01;
                  fmt = (r.loop_rem == 8'h01);
                  n.st = CMD_LEN;
                  if (byte_i <= fip_tail_pkg::TAG_LAST) begin
                     n.seen_pkt[byte_i[3:0]] = 1'b1;
                  end else begin
                     n.seen_pkt[fip_tail_pkg::SEEN_RSVD] = 1'b1;
                  end
               end
               CMD_LEN: begin
                  rem = r.loop_rem - 8'h01;
                  fmt = (byte_i > rem);
                  n.loop_rem = rem;
                  n.body_rem = byte_i;
                  n.body_idx = 2'h0;
                  if (byte_i != 8'h00) begin
                     n.st = CMD_BODY;
                  end else begin
                     n.st = (rem == 8'h00) ? CRC : CMD_TAG;
                  end
               end
               CMD_BODY: begin
                  n.loop_rem = r.loop_rem - 8'h01;
                  n.body_rem = r.body_rem - 8'h01;
                  if (r.body_idx != 2'h3) begin
                     n.body_idx = r.body_idx + 2'h1;
                  end
                  if (r.tag == fip_tail_pkg::TAG_TIME_SHIFT) begin
                     if (r.body_idx == 2'h0) begin
                        n.ts_hi = byte_i;
                     end else if (r.body_idx == 2'h1) begin
                        n.ts_pkt = {r.ts_hi, byte_i};
                        n.ts_ok = 1'b1;
                     end
                  end
                  if (r.body_rem == 8'h01) begin
                     n.st = (r.loop_rem == 8'h01) ? CRC : CMD_TAG;
                  end
               end
               CRC: begin
                  n.crc_cnt = r.crc_cnt + 2'h1;
                  if (r.crc_cnt == 2'h3) begin
                     fmt = (r.sec_rem != 8'h01);
                     n.crc_chk = (r.sec_rem == 8'h01);
                     n.st = PAD;
                  end
               end
               PAD: begin
                  if (byte_i != fip_tail_pkg::PAD_BYTE) begin
                     set[fip_tail_pkg::ST_PAD] = 1'b1;
                  end
               end
               default: n.st = SKIP;
            endcase
            if (r.pos == fip_tail_pkg::POS_LAST && n.st != PAD && n.st != SKIP &&
                n.st != IDLE) begin
               fmt = 1'b1;
            end
            if (fmt) begin
               set[fip_tail_pkg::ST_FMT] = 1'b1;
               n.err_p = 1'b1;
               n.crc_chk = 1'b0;
               n.st = SKIP;
            end
            if (r.pos == fip_tail_pkg::POS_LAST) begin
               n.st = IDLE;
            end
         end
      end

      // sticky status, set beats clear
      n.status = (r.status & ~clr) | set;

      if (rst_i) begin
         n = '0;
         n.st = IDLE;
         n.waitreq = 1'b1;
         n.enable = fip_tail_pkg::RST_ENABLE;
         n.own_id = fip_tail_pkg::RST_OWN_ID;
         n.grp_id = fip_tail_pkg::RST_GRP_ID;
      end
   end

   // register the whole state
   always_ff @(posedge clk_i) begin
      r <= n;
   end

   //-------------------------------------------------------------------------
   // outputs straight from state
   //-------------------------------------------------------------------------
   assign readdata_o = r.rdata;
   assign waitrequest_o = r.waitreq;
   assign tps_param_o = r.tps_act[21:0];
   assign bw_code_o = r.tps_act[23:fip_tail_pkg::TPS_BW_LO];
   assign hp_stream_o = r.tps_act[fip_tail_pkg::TPS_PRIO];
   assign time_shift_o = r.ts_act;
   assign ref_time_o = r.ref_act;
   assign emit_time_o = r.emit_act;
   assign pkt_ok_o = r.ok_p;
   assign pkt_err_o = r.err_p;

endmodule
`default_nettype wire

// File: testbench/fip_tail_properties.sv
// concurrent checks on the packet tail parser ports
`timescale 1ns/1ps
`default_nettype none
module fip_tail_checker (
   input wire logic        clk_i, rst_i, frame_start_i, read_i, write_i, waitrequest_o,
   input wire logic        hp_stream_o, pkt_ok_o, pkt_err_o,
   input wire logic [21:0] tps_param_o,
   input wire logic [1:0]  bw_code_o,
   input wire logic [15:0] time_shift_o,
   input wire logic [23:0] ref_time_o, emit_time_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // expected emit time: reference plus signed shift, wrapped into one second
   logic signed [26:0] sum, wrap;
   assign sum  = $signed({3'h0, ref_time_o}) + $signed(time_shift_o);
   assign wrap = sum < 0 ? sum + 27'sh0989680 : sum >= 27'sh0989680 ? sum - 27'sh0989680 : sum;

   bus_answer_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("bus request not answered");
   answer_once_a: assert property (!waitrequest_o |=> waitrequest_o)
      else $error("waitrequest low too long");
   no_request_a: assert property (!read_i && !write_i && waitrequest_o |=> waitrequest_o)
      else $error("answer without request");
   verdict_excl_a: assert property (!(pkt_ok_o && pkt_err_o))
      else $error("ok and error together");
   ok_pulse_a: assert property (pkt_ok_o |=> !pkt_ok_o)
      else $error("ok pulse too long");
   applied_hold_a: assert property (!frame_start_i && !$past(frame_start_i) |=>
      $stable({hp_stream_o, bw_code_o, tps_param_o, time_shift_o})) else $error("moved off frame");
   emit_sum_a: assert property (emit_time_o == wrap[23:0])
      else $error("emit time not ref plus shift");
   ref_range_a: assert property (ref_time_o < 24'h989680)
      else $error("ref time not wrapped");

   cover property (pkt_ok_o);
   cover property (pkt_err_o);
   cover property ($changed(time_shift_o));
endmodule
bind fip_tail_parser fip_tail_checker chk (.*);
`default_nettype wire

// File: testbench/ts_source.sv
// transport packet source feeding the parser one byte per cycle
`timescale 1ns/1ps
`default_nettype none
module ts_source (
   // clock
   input  wire logic       clk_i,
   // byte stream
   output logic      [7:0] byte_o,
   output logic            valid_o,
   output logic            start_o
);
   logic [7:0] pkt [188];
   initial {byte_o, valid_o, start_o} = 10'h0;
   // one byte through the section crc, msb first
   function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--) c = {c[30:0], 1'b0} ^ (c[31] ^ d[i] ? 32'h04c11db7 : 32'h0);
      return c;
   endfunction
   // build header, section, crc and pads, then send all bytes
   task automatic send(input logic [31:0] w, input logic [47:0] tm, input logic [7:0] t[$],
                       input logic [1:0] bad);
      logic [159:0] h;
      logic [31:0]  c;
      int           n;
      n = 20 + t.size();
      h = {32'h47401510 ^ {23'h0, bad[1], 8'h00}, 8'h00, 8'(n - 2), 32'h00000001, tm, w};
      c = 32'hffffffff;
      for (int i = 0; i < 188; i++) begin
         pkt[i] = i < 20 ? h[159 - 8 * i -: 8] : i < n ? t[i - 20] : 8'hff;
         if (i >= 4 && i < n) c = crc8(c, pkt[i]);
      end
      {pkt[n], pkt[n + 1], pkt[n + 2], pkt[n + 3]} = c ^ 32'(bad[0]);
      for (int i = 0; i < 188; i++) begin
         @(posedge clk_i);
         {byte_o, valid_o, start_o} <= {pkt[i], 1'b1, i == 0};
      end
      @(posedge clk_i);
      {byte_o, valid_o, start_o} <= {~byte_o, 2'b00};
   endtask
endmodule
`default_nettype wire

// File: testbench/frame_init_packet_tail_parser_test.sv
// self-checking bench for the packet tail parser
`timescale 1ns/1ps
`default_nettype none
module frame_init_packet_tail_parser_test;
   logic        clk_i, rst_i, byte_valid_i, pkt_start_i, frame_start_i, read_i, write_i;
   logic        waitrequest_o, hp_stream_o, pkt_ok_o, pkt_err_o;
   logic [7:0]  byte_i;
   logic [5:0]  address_i;
   logic [31:0] writedata_i, readdata_o, q;
   logic [21:0] tps_param_o, prev;
   logic [1:0]  bw_code_o;
   logic [15:0] time_shift_o;
   logic [23:0] ref_time_o, emit_time_o;
   logic [47:0] tm;
   int          bad_count, n_tests, ok_cnt, err_cnt;
   fip_tail_parser uut (.*);
   ts_source src (.clk_i(clk_i), .byte_o(byte_i), .valid_o(byte_valid_i), .start_o(pkt_start_i));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   // count verdict pulses
   always @(posedge clk_i) begin
      if (pkt_ok_o === 1'b1) ok_cnt++;
      if (pkt_err_o === 1'b1) err_cnt++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      {write_i, read_i, address_i, writedata_i} <= {wr, !wr, a, d};
      do @(posedge clk_i); while (waitrequest_o !== 1'b0);
      q = readdata_o;
      {write_i, read_i} <= 2'b00;
      @(posedge clk_i);
   endtask
   task automatic frame();
      frame_start_i <= 1'b1;
      @(posedge clk_i);
      frame_start_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #2000000;
      bad_count++;
      summarize();
   end
   initial begin
      {rst_i, frame_start_i, read_i, write_i, address_i, writedata_i} = {4'h8, 38'h0};
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check(32'({waitrequest_o, pkt_ok_o, tps_param_o}), 32'h00800000);
      bus(0, fip_tail_pkg::OFF_CTRL, 0); check(q, 32'h1);
      bus(0, fip_tail_pkg::OFF_TXID, 0); check(q, 32'h00010001);
      bus(1, fip_tail_pkg::OFF_TPS, 32'hffffffff);
      bus(0, fip_tail_pkg::OFF_TPS, 0); check(q, 32'h0);
      bus(0, 6'h20, 0); check(q, 32'h0);
      prev = 22'h0;
      tm = 48'h98967f000002;
      // every bandwidth code, no addressing
      for (int k = 0; k < 4; k++) begin
         src.send({7'h00, k[0], k[1:0], 22'h2aaaa5 ^ 22'(k)}, tm, '{8'h00}, 1'b0);
         frame();
         check(32'(tps_param_o), 32'(prev));
         frame();
         prev = 22'h2aaaa5 ^ 22'(k);
         check(32'({hp_stream_o, bw_code_o, tps_param_o}), 32'({k[0], k[1:0], prev}));
      end
      check(32'(emit_time_o), 32'h1);
      check(32'(ref_time_o), 32'h1);
      check(32'(ok_cnt), 32'h4);
      bus(1, fip_tail_pkg::OFF_STATUS, 32'h1f);
      // own address, shift, reserved code, empty command
      src.send(0, tm, '{8'h02, 8'h00, 8'h01, 8'h09, 8'h00, 8'h02, 8'hff, 8'hfd, 8'h0b, 8'h01,
                        8'haa, 8'h01, 8'h00}, 1'b0);
      frame();
      check(32'(time_shift_o), 32'hfffd);
      check(32'(emit_time_o), 32'h98967e);
      bus(0, fip_tail_pkg::OFF_SEEN, 0); check(q, 32'h803);
      bus(0, fip_tail_pkg::OFF_STATUS, 0); check(q, 32'h1);
      src.send(0, tm, '{8'hff, 8'h00, 8'h00, 8'h04, 8'h00, 8'h02, 8'h00, 8'h05}, 1'b0);
      frame();
      check(32'(time_shift_o), 32'h5);
      src.send(0, tm, '{8'h02, 8'h00, 8'h07, 8'h04, 8'h00, 8'h02, 8'h00, 8'h09}, 1'b0);
      frame();
      check(32'(time_shift_o), 32'h5);
      bus(1, fip_tail_pkg::OFF_STATUS, 32'h1f);
      // command overrun, then a corrupted crc
      src.send(0, tm, '{8'h02, 8'h00, 8'h01, 8'h04, 8'h00, 8'h05, 8'h00, 8'h00}, 1'b0);
      src.send(0, tm, '{8'h00}, 1'b1);
      src.send(0, tm, '{8'h00}, 2'h2);
      bus(0, fip_tail_pkg::OFF_STATUS, 0); check(q, 32'h6);
      check(32'(err_cnt), 32'h2);
      check(32'(ok_cnt), 32'h7);
      summarize();
   end
endmodule
`default_nettype wire
